/* File: ccc_pkg.sv */
// Notes on behaviour
// - Two-bit select picks period, 3.9 to 250 ms.
// - Integration restarts at once, no idle gap.
// - Calibration runs eight shorted-input measurements.
// - Offset stored in ten bits, done pulse raised.
// - Calibration request bit clears itself when done.
// - Clear request zeroes offset, count, accumulator; self-clears.
// - Hold freezes results; integrator keeps running.
// - Period ending under hold is discarded.
// - Dither set bit enables converter dithering.
// - Result clear leaves dither state alone.
// - Dither reset bit disables dithering.
// - Dither state readable as status bit.
// - After calibration gauge enters normal gauging itself.
// - Sample counter and accumulator readable by host.
// - Sample-done pulse on each result captured while gauging, not under hold.
// - Last integration result held in fourteen bits.
package ccc_pkg;
  localparam longint CLK_HZ      = 40_000_000;
  // Integration periods and modulator sample interval, in ns
  localparam longint PERIOD0_NS  = 3_900_000;
  localparam longint PERIOD1_NS  = 62_500_000;
  localparam longint PERIOD2_NS  = 125_000_000;
  localparam longint PERIOD3_NS  = 250_000_000;
  localparam longint MOD_TICK_NS = 32_000;

  function automatic int ns_to_cyc(input longint ns);
    longint c;
    c = (ns * CLK_HZ) / 64'd1_000_000_000;
    return (c < 1) ? 1 : int'(c);
  endfunction

  localparam int PERIOD0_CYC  = ns_to_cyc(PERIOD0_NS);
  localparam int PERIOD1_CYC  = ns_to_cyc(PERIOD1_NS);
  localparam int PERIOD2_CYC  = ns_to_cyc(PERIOD2_NS);
  localparam int PERIOD3_CYC  = ns_to_cyc(PERIOD3_NS);
  localparam int MOD_TICK_CYC = ns_to_cyc(MOD_TICK_NS);

  // Field widths
  localparam int INTEG_W  = 14;
  localparam int OFFSET_W = 10;
  localparam int COUNT_W  = 24;
  localparam int ACCUM_W  = 32;
  localparam int TIMER_W  = 24;
  localparam int CAL_RUNS = 8;
  localparam int CAL_SHIFT = 3;

  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_TOGGLE  = 8'h04;
  localparam logic [7:0] ADDR_OFFSET  = 8'h08;
  localparam logic [7:0] ADDR_INTEG   = 8'h0C;
  localparam logic [7:0] ADDR_COUNT   = 8'h10;
  localparam logic [7:0] ADDR_ACCUM   = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;

  // gauge_control_reg fields
  localparam int CTL_PSEL_LO = 0;
  localparam int CTL_HOLD    = 2;
  localparam int CTL_CAL     = 3;
  localparam int CTL_CLEAR   = 4;
  // toggle_control_reg write strobes and read bits
  localparam int TGL_EN_SET  = 0;
  localparam int TGL_EN_CLR  = 1;
  localparam int TGL_DIT_SET = 2;
  localparam int TGL_DIT_CLR = 3;
  localparam int TGL_RD_EN   = 0;
  localparam int TGL_RD_DIT  = 1;
  // status fields
  localparam int STS_CAL     = 0;
  localparam int STS_RUN     = 1;

  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_CAL} ccc_state_t;
endpackage

/* File: ccc_sync.sv */
`timescale 1ns/100ps
module ccc_sync import ccc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta;
  logic next_meta;
  logic next_q;

  // Two stages; only the second stage is read
  always_comb
  begin
    next_meta = d_i;
    next_q    = meta;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end
    else
    begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end
endmodule

/* File: ccc_integ.sv */
`timescale 1ns/100ps
module ccc_integ import ccc_pkg::*;
#(
  parameter int P0_CYC  = PERIOD0_CYC,
  parameter int P1_CYC  = PERIOD1_CYC,
  parameter int P2_CYC  = PERIOD2_CYC,
  parameter int P3_CYC  = PERIOD3_CYC,
  parameter int TICK_CYC = MOD_TICK_CYC
)
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                run_i,
  input  wire logic                restart_i,
  input  wire logic [1:0]          psel_i,
  input  wire logic                bit_i,
  output logic                     done_o,
  output logic signed [INTEG_W-1:0] result_o
);
  localparam logic signed [INTEG_W-1:0] MAXV = {1'b0, {(INTEG_W-1){1'b1}}};
  localparam logic signed [INTEG_W-1:0] MINV = {1'b1, {(INTEG_W-1){1'b0}}};

  logic [TIMER_W-1:0]        timer;
  logic [TIMER_W-1:0]        tick;
  logic signed [INTEG_W-1:0] acc;
  logic [TIMER_W-1:0]        next_timer;
  logic [TIMER_W-1:0]        next_tick;
  logic signed [INTEG_W-1:0] next_acc;
  logic                      next_done;
  logic signed [INTEG_W-1:0] next_result;
  logic [TIMER_W-1:0]        limit;

  // Four codes, four distinct lengths
  function automatic logic [TIMER_W-1:0] period_of(input logic [1:0] s);
    case (s)
      2'h0:    return TIMER_W'(P0_CYC - 1);
      2'h1:    return TIMER_W'(P1_CYC - 1);
      2'h2:    return TIMER_W'(P2_CYC - 1);
      default: return TIMER_W'(P3_CYC - 1);
    endcase
  endfunction

  // Up/down count of modulator ones, saturating at the field range
  always_comb
  begin
    limit       = period_of(psel_i);
    next_timer  = timer + 1'b1;
    next_tick   = tick + 1'b1;
    next_acc    = acc;
    next_done   = 1'b0;
    next_result = result_o;
    if (tick >= TIMER_W'(TICK_CYC - 1))
    begin
      next_tick = '0;
      // A one-bit signed literal would read as minus one here
      if (bit_i && acc != MAXV)
        next_acc = acc + INTEG_W'(1);
      else if (!bit_i && acc != MINV)
        next_acc = acc - INTEG_W'(1);
    end
    // Period end: hand over result and begin next at once
    if (timer >= limit)
    begin
      next_done   = 1'b1;
      next_result = next_acc;
      next_timer  = '0;
      next_tick   = '0;
      next_acc    = '0;
    end
    if (!run_i || restart_i)
    begin
      next_timer = '0;
      next_tick  = '0;
      next_acc   = '0;
      next_done  = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timer    <= '0;
      tick     <= '0;
      acc      <= '0;
      done_o   <= 1'b0;
      result_o <= '0;
    end
    else
    begin
      timer    <= next_timer;
      tick     <= next_tick;
      acc      <= next_acc;
      done_o   <= next_done;
      result_o <= next_result;
    end
  end
endmodule

/* File: ccc_top.sv */
`timescale 1ns/100ps
module ccc_top import ccc_pkg::*;
#(
  parameter int P0_CYC   = PERIOD0_CYC,
  parameter int P1_CYC   = PERIOD1_CYC,
  parameter int P2_CYC   = PERIOD2_CYC,
  parameter int P3_CYC   = PERIOD3_CYC,
  parameter int TICK_CYC = MOD_TICK_CYC
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Classic Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Converter side
  input  wire logic        mod_bit_i,
  output logic             conv_enable_o,
  output logic             short_inputs_o,
  output logic             dither_en_o,
  // Event pulses
  output logic             sample_done_o,
  output logic             cal_done_o
);
  logic                       mod_bit;
  logic                       integ_done;
  logic signed [INTEG_W-1:0]  integ_res;
  logic                       integ_restart;

  // Bus request phases
  logic        req;
  logic        wr_go;
  logic        next_ack;
  logic [31:0] next_dat;

  // Control state
  logic [1:0] period_select;
  logic       update_hold;
  logic       calibration_request;
  logic       result_clear_request;
  logic       gauge_enable;
  logic       dither_active;
  logic [1:0] next_period_select;
  logic       next_update_hold;
  logic       next_calibration_request;
  logic       next_result_clear_request;
  logic       next_gauge_enable;
  logic       next_dither_active;

  // Sequencer state
  ccc_state_t                      state;
  logic [2:0]                      cal_cnt;
  logic signed [INTEG_W+2:0]       cal_sum;
  logic signed [OFFSET_W-1:0]      offset_error_result;
  logic                            cal_finish;
  ccc_state_t                      next_state;
  logic [2:0]                      next_cal_cnt;
  logic signed [INTEG_W+2:0]       next_cal_sum;
  logic signed [OFFSET_W-1:0]      next_offset;
  logic                            next_cal_done;
  logic signed [INTEG_W+2:0]       sum_now;

  // Results
  logic signed [INTEG_W-1:0]  last_integration_result;
  logic [COUNT_W-1:0]         sample_count;
  logic [ACCUM_W-1:0]         charge_accumulator;
  logic signed [INTEG_W-1:0]  next_integ;
  logic [COUNT_W-1:0]         next_count;
  logic [ACCUM_W-1:0]         next_accum;
  logic                       next_sample_done;

  // Average of the calibration sum, clamped to the offset field
  function automatic logic signed [OFFSET_W-1:0] avg_offset(
    input logic signed [INTEG_W+2:0] s);
    logic signed [INTEG_W+2:0] a;
    a = s >>> CAL_SHIFT;
    if (a > (INTEG_W+3)'(2**(OFFSET_W-1) - 1))
      return {1'b0, {(OFFSET_W-1){1'b1}}};
    else if (a < -(INTEG_W+3)'(2**(OFFSET_W-1)))
      return {1'b1, {(OFFSET_W-1){1'b0}}};
    else
      return a[OFFSET_W-1:0];
  endfunction

  // Modulator output comes from the analog side
  ccc_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (mod_bit_i),
    .q_o   (mod_bit)
  );

  ccc_integ #(
    .P0_CYC   (P0_CYC),
    .P1_CYC   (P1_CYC),
    .P2_CYC   (P2_CYC),
    .P3_CYC   (P3_CYC),
    .TICK_CYC (TICK_CYC)
  ) u_integ (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .run_i     (gauge_enable),
    .restart_i (integ_restart),
    .psel_i    (period_select),
    .bit_i     (mod_bit),
    .done_o    (integ_done),
    .result_o  (integ_res)
  );

  // Writes commit on the edge where the master sees ack
  assign req   = wb_cyc_i & wb_stb_i;
  assign wr_go = req & wb_we_i & wb_ack_o & wb_sel_i[0];

  // Bus answer one cycle after the request; unmapped reads as zero
  always_comb
  begin
    next_ack = req & ~wb_ack_o;
    next_dat = '0;
    case (wb_adr_i)
      ADDR_CONTROL:
      begin
        next_dat[CTL_PSEL_LO +: 2] = period_select;
        next_dat[CTL_HOLD]         = update_hold;
        next_dat[CTL_CAL]          = calibration_request;
        next_dat[CTL_CLEAR]        = result_clear_request;
      end
      ADDR_TOGGLE:
      begin
        next_dat[TGL_RD_EN]  = gauge_enable;
        next_dat[TGL_RD_DIT] = dither_active;
      end
      ADDR_OFFSET: next_dat[OFFSET_W-1:0] = offset_error_result;
      ADDR_INTEG:  next_dat[INTEG_W-1:0]  = last_integration_result;
      ADDR_COUNT:  next_dat[COUNT_W-1:0]  = sample_count;
      ADDR_ACCUM:  next_dat               = charge_accumulator;
      ADDR_STATUS:
      begin
        next_dat[STS_CAL] = (state == ST_CAL);
        next_dat[STS_RUN] = (state == ST_RUN);
      end
      default:     next_dat = '0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // Control bits; a host set in the clearing cycle survives
  always_comb
  begin
    next_period_select        = period_select;
    next_update_hold          = update_hold;
    next_calibration_request  = calibration_request;
    next_result_clear_request = 1'b0;
    next_gauge_enable         = gauge_enable;
    next_dither_active        = dither_active;
    if (cal_finish)
      next_calibration_request = 1'b0;
    if (wr_go && wb_adr_i == ADDR_CONTROL)
    begin
      next_period_select        = wb_dat_i[CTL_PSEL_LO +: 2];
      next_update_hold          = wb_dat_i[CTL_HOLD];
      next_result_clear_request = wb_dat_i[CTL_CLEAR];
      if (wb_dat_i[CTL_CAL])
        next_calibration_request = 1'b1;
    end
    if (wr_go && wb_adr_i == ADDR_TOGGLE)
    begin
      if (wb_dat_i[TGL_EN_SET])
        next_gauge_enable = 1'b1;
      else if (wb_dat_i[TGL_EN_CLR])
        next_gauge_enable = 1'b0;
      if (wb_dat_i[TGL_DIT_SET])
        next_dither_active = 1'b1;
      else if (wb_dat_i[TGL_DIT_CLR])
        next_dither_active = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      period_select        <= '0;
      update_hold          <= 1'b0;
      calibration_request  <= 1'b0;
      result_clear_request <= 1'b0;
      gauge_enable         <= 1'b0;
      dither_active        <= 1'b0;
    end
    else
    begin
      period_select        <= next_period_select;
      update_hold          <= next_update_hold;
      calibration_request  <= next_calibration_request;
      result_clear_request <= next_result_clear_request;
      gauge_enable         <= next_gauge_enable;
      dither_active        <= next_dither_active;
    end
  end

  // Sequencer: off, gauging, calibrating
  // A request made while disabled waits until the gauge is enabled
  always_comb
  begin
    next_state    = state;
    next_cal_cnt  = cal_cnt;
    next_cal_sum  = cal_sum;
    next_offset   = offset_error_result;
    next_cal_done = 1'b0;
    integ_restart = 1'b0;
    cal_finish    = 1'b0;
    sum_now       = cal_sum + (INTEG_W+3)'(integ_res);
    case (state)
      ST_OFF:
      begin
        if (gauge_enable)
          next_state = ST_RUN;
      end
      ST_RUN:
      begin
        if (!gauge_enable)
          next_state = ST_OFF;
        else if (calibration_request)
        begin
          // Restart so every calibration period is fully shorted
          integ_restart = 1'b1;
          next_cal_cnt  = '0;
          next_cal_sum  = '0;
          next_state    = ST_CAL;
        end
      end
      ST_CAL:
      begin
        if (!gauge_enable)
          next_state = ST_OFF;
        else if (integ_done)
        begin
          next_cal_sum = sum_now;
          next_cal_cnt = cal_cnt + 1'b1;
          if (cal_cnt == 3'(CAL_RUNS - 1))
          begin
            next_offset   = avg_offset(sum_now);
            next_cal_done = 1'b1;
            cal_finish    = 1'b1;
            next_state    = ST_RUN;
          end
        end
      end
      default: next_state = ST_OFF;
    endcase
    // A finishing calibration outranks a clear in the same cycle
    if (result_clear_request && !cal_finish)
      next_offset = '0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state               <= ST_OFF;
      cal_cnt             <= '0;
      cal_sum             <= '0;
      offset_error_result <= '0;
      cal_done_o          <= 1'b0;
    end
    else
    begin
      state               <= next_state;
      cal_cnt             <= next_cal_cnt;
      cal_sum             <= next_cal_sum;
      offset_error_result <= next_offset;
      cal_done_o          <= next_cal_done;
    end
  end

  // Result capture; a held period's value is simply dropped
  always_comb
  begin
    next_integ       = last_integration_result;
    next_count       = sample_count;
    next_accum       = charge_accumulator;
    next_sample_done = 1'b0;
    if (state == ST_RUN && integ_done && !update_hold)
    begin
      next_integ       = integ_res;
      next_count       = sample_count + 1'b1;
      next_accum       = charge_accumulator + ACCUM_W'(integ_res);
      next_sample_done = 1'b1;
    end
    if (result_clear_request)
    begin
      next_count = '0;
      next_accum = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      last_integration_result <= '0;
      sample_count            <= '0;
      charge_accumulator      <= '0;
      sample_done_o           <= 1'b0;
    end
    else
    begin
      last_integration_result <= next_integ;
      sample_count            <= next_count;
      charge_accumulator      <= next_accum;
      sample_done_o           <= next_sample_done;
    end
  end

  // Converter controls straight from state
  assign conv_enable_o  = gauge_enable;
  assign short_inputs_o = (state == ST_CAL);
  assign dither_en_o    = dither_active;
endmodule

/* File: ccc_assertions.sv */
`timescale 1ns/100ps
module ccc_assertions import ccc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        conv_enable_o,
  input wire logic        short_inputs_o,
  input wire logic        dither_en_o,
  input wire logic        sample_done_o,
  input wire logic        cal_done_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Committing writes, seen at the ack edge where the master still holds data
  logic wr_cmt;
  logic tgl_wr;
  logic ctl_wr;
  assign wr_cmt = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  assign tgl_wr = wr_cmt && (wb_adr_i == ADDR_TOGGLE);
  assign ctl_wr = wr_cmt && (wb_adr_i == ADDR_CONTROL);

  property p_ack_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack missing after request");
  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
  property p_no_sample_off;
    !conv_enable_o [*4] |-> !sample_done_o;
  endproperty
  a_no_sample_off: assert property (p_no_sample_off) else $error("sample while off");
  property p_no_sample_cal;
    short_inputs_o [*3] |-> !sample_done_o;
  endproperty
  a_no_sample_cal: assert property (p_no_sample_cal) else $error("sample during cal");
  property p_cal_start;
    ctl_wr && wb_dat_i[CTL_CAL] && conv_enable_o |-> ##[1:3] short_inputs_o;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration did not start");
  property p_cal_end;
    $fell(short_inputs_o) && conv_enable_o |-> ##[0:2] cal_done_o;
  endproperty
  a_cal_end: assert property (p_cal_end) else $error("no done pulse after cal");
  property p_en_set;
    tgl_wr && wb_dat_i[TGL_EN_SET] |-> ##[1:2] conv_enable_o;
  endproperty
  a_en_set: assert property (p_en_set) else $error("gauge not enabled");
  property p_dith_set;
    tgl_wr && wb_dat_i[TGL_DIT_SET] |=> dither_en_o;
  endproperty
  a_dith_set: assert property (p_dith_set) else $error("dither not set");
  property p_dith_clr;
    tgl_wr && wb_dat_i[TGL_DIT_CLR] && !wb_dat_i[TGL_DIT_SET] |=> !dither_en_o;
  endproperty
  a_dith_clr: assert property (p_dith_clr) else $error("dither not cleared");
  property p_dith_keep;
    ctl_wr |=> $stable(dither_en_o);
  endproperty
  a_dith_keep: assert property (p_dith_keep) else $error("dither moved by control");
  property p_sd_gap;
    sample_done_o |=> !sample_done_o [*8];
  endproperty
  a_sd_gap: assert property (p_sd_gap) else $error("sample pulses too close");

  // Main scenarios reached
  c_cal_done: cover property (cal_done_o);
  c_sample: cover property (sample_done_o ##[1:120] sample_done_o);
  c_dith_off: cover property ($fell(dither_en_o));
endmodule

bind ccc_top ccc_assertions ccc_assertions_i (
  .clk_i          (clk_i),
  .rst_i          (rst_i),
  .wb_cyc_i       (wb_cyc_i),
  .wb_stb_i       (wb_stb_i),
  .wb_we_i        (wb_we_i),
  .wb_adr_i       (wb_adr_i),
  .wb_sel_i       (wb_sel_i),
  .wb_dat_i       (wb_dat_i),
  .wb_ack_o       (wb_ack_o),
  .conv_enable_o  (conv_enable_o),
  .short_inputs_o (short_inputs_o),
  .dither_en_o    (dither_en_o),
  .sample_done_o  (sample_done_o),
  .cal_done_o     (cal_done_o)
);

/* File: test_coulomb_counter_control.sv */
`timescale 1ns/100ps
module test_coulomb_counter_control import ccc_pkg::*;;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} ccc_row_t;
  // Shortened periods keep the run small
  localparam int PER [4] = '{40, 60, 80, 100};
  localparam ccc_row_t ROWS [19] = '{
    '{1'h0, 8'h00, 32'h0, 32'h0}, '{1'h0, 8'h04, 32'h0, 32'h0}, '{1'h0, 8'h08, 32'h0, 32'h0},
    '{1'h0, 8'h0C, 32'h0, 32'h0}, '{1'h0, 8'h10, 32'h0, 32'h0}, '{1'h0, 8'h14, 32'h0, 32'h0},
    '{1'h0, 8'h18, 32'h0, 32'h0}, '{1'h1, 8'h1C, 32'hFFFFFFFF, 32'h0},
    '{1'h0, 8'h1C, 32'h0, 32'h0}, '{1'h1, 8'h00, 32'h3, 32'h0}, '{1'h0, 8'h00, 32'h0, 32'h3},
    '{1'h1, 8'h00, 32'h0, 32'h0}, '{1'h0, 8'h00, 32'h0, 32'h0}, '{1'h1, 8'h04, 32'h4, 32'h0},
    '{1'h0, 8'h04, 32'h0, 32'h2}, '{1'h1, 8'h04, 32'hC, 32'h0}, '{1'h0, 8'h04, 32'h0, 32'h2},
    '{1'h1, 8'h04, 32'h8, 32'h0}, '{1'h0, 8'h04, 32'h0, 32'h0}};
  logic        clk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        mod_bit;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [3:0]  bsel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [31:0] sum;
  logic        ack;
  logic        conv_en;
  logic        short_in;
  logic        dith;
  logic        sd;
  logic        cd;
  int          num_errors = 0;
  int          num_checks = 0;
  int          n;

  ccc_top #(.P0_CYC(40), .P1_CYC(60), .P2_CYC(80), .P3_CYC(100), .TICK_CYC(4)) ccc_top_i (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .mod_bit_i(mod_bit),
    .conv_enable_o(conv_en), .short_inputs_o(short_in), .dither_en_o(dith),
    .sample_done_o(sd), .cal_done_o(cd));

  // Free-running 40 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single cycle; data taken only at the edge that sees ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= bsel;
    wdat <= d;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'h1 && k < 100);
    chk({31'h0, ack}, 32'h1);
    r = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'h1, a, d, r);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0, q);
    chk(q, e);
  endtask

  // Edges until the next sample pulse, bounded
  task wait_sd(output int c);
    c = 0;
    do
    begin
      @(posedge clk);
      c++;
    end
    while (sd !== 1'h1 && c < 1000);
    chk({31'h0, sd}, 32'h1);
  endtask

  task summarize;
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard, well beyond the few thousand cycles needed
  initial
  begin
    repeat (30000) @(posedge clk);
    num_errors++;
    $display("[ERR] %0t timeout", $time);
    summarize;
  end

  initial
  begin
    {rst, cyc, stb, we, mod_bit, adr, wdat} = {1'h1, 44'h0};
    {sel, bsel} = 8'hFF;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    chk({26'h0, ack, conv_en, short_in, dith, sd, cd}, 32'h0);
    // Table: reset values, unmapped place, period codes, dither bits
    foreach (ROWS[i])
      if (ROWS[i].w)
        wr(ROWS[i].a, ROWS[i].d);
      else
        rd(ROWS[i].a, ROWS[i].e);
    // A write without its low byte lane is ignored
    bsel = 4'hE;
    wr(8'h00, 32'h3);
    bsel = 4'hF;
    rd(8'h00, 32'h0);
    mod_bit <= 1'h1;
    wr(8'h04, 32'h1);
    rd(8'h04, 32'h1);
    // Each select code gives its own back-to-back period
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h00, 32'h4 | (p > 0 ? p - 1 : 0));
      wr(8'h00, 32'h4 | p);
      wr(8'h00, p);
      wait_sd(n);
      wait_sd(n);
      chk(n, PER[p]);
    end
    // Clear under hold, dither left alone
    wr(8'h04, 32'h4);
    wr(8'h00, 32'h7);
    wr(8'h00, 32'h14);
    rd(8'h08, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h00, 32'h4);
    rd(8'h04, 32'h3);
    chk({30'h0, conv_en, dith}, 32'h3);
    wr(8'h00, 32'h0);
    sum = 32'h0;
    for (int k = 1; k <= 3; k++)
    begin
      wait_sd(n);
      wb(1'h0, 8'h0C, 32'h0, q);
      chk({31'h0, !q[13] && q[12:0] != 13'h0}, 32'h1);
      sum = sum + {{18{q[13]}}, q[13:0]};
      rd(8'h10, k);
      rd(8'h14, sum);
    end
    // Hold: no pulses, counter frozen, then prompt restart
    wr(8'h00, 32'h4);
    n = 0;
    repeat (250) @(posedge clk) n += sd;
    chk(n, 0);
    rd(8'h10, 32'h3);
    wr(8'h00, 32'h0);
    wait_sd(n);
    chk({31'h0, n <= PER[0]}, 32'h1);
    mod_bit <= 1'h0;
    wait_sd(n);
    wait_sd(n);
    wb(1'h0, 8'h0C, 32'h0, q);
    chk({31'h0, q[13]}, 32'h1);
    // Calibration: eight shorted periods, then gauging on its own
    mod_bit <= 1'h1;
    wr(8'h00, 32'h8);
    n = 0;
    for (int k = 0; k < 2000 && cd !== 1'h1; k++)
    begin
      @(posedge clk);
      n += short_in;
    end
    chk({31'h0, cd}, 32'h1);
    chk({31'h0, n >= 8 * PER[0] - 2 && n <= 8 * PER[0] + 2}, 32'h1);
    rd(8'h00, 32'h0);
    wb(1'h0, 8'h08, 32'h0, q);
    chk({31'h0, !q[9] && q[8:0] != 9'h0}, 32'h1);
    rd(8'h18, 32'h2);
    wait_sd(n);
    chk({31'h0, n <= PER[0]}, 32'h1);
    // Reset in mid-run while gauging with dither on
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    chk({26'h0, ack, conv_en, short_in, dith, sd, cd}, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h04, 32'h0);
    summarize;
  end
endmodule
